// file: core/mce_params.svh
// Purpose: Constants of the metering engine support block
// Assumes: Included by design files only
// Notes: Register byte address is four times its index
`ifndef MCE_PARAMS_SVH
`define MCE_PARAMS_SVH
`define MCE_IDX_CTRL 14'h2000
`define MCE_IDX_ACC 14'h2001
`define MCE_IDX_INTV 14'h2002
`define MCE_IDX_WLIM 14'h2003
`define MCE_IDX_MON0 14'h2004
`define MCE_IDX_MON3 14'h2007
`define MCE_IDX_STAT 14'h2008
`define MCE_IDX_NONE 14'h3fff
`define MCE_CTRL_EQU_MSB 2
`define MCE_CTRL_EQU_LSB 0
`define MCE_CTRL_MON_EN 3
`define MCE_CTRL_INV 4
`define MCE_PRE_MSB 7
`define MCE_PRE_LSB 6
`define MCE_SUM_MSB 5
`define MCE_SUM_LSB 0
`define MCE_EQU_MAX 3'h5
`define MCE_EQU_RST 3'h0
`define MCE_ACC_RST 8'h00
`define MCE_INTV_RST 8'h00
`define MCE_WLIM_RST 8'hff
`define MCE_WLIM_OFF 8'hff
`define MCE_INTV_UNIT 2
`define MCE_FIFO_DEPTH 3'h4
`define MCE_RTM_LAST_BIT 6'h22
`define MCE_RTM_LAST_WORD 2'h3
`endif

// file: core/mce_pkg.sv
// Purpose: Types of the metering engine support block
// Assumes: Nothing
// Notes: State codes are Gray along the usual path
package mce_pkg;
	typedef enum logic [1:0] {
		MCE_PASS_IDLE = 2'h0,
		MCE_PASS_FETCH = 2'h1,
		MCE_PASS_RUN = 2'h3
	} mce_pass_e;
	typedef enum logic [1:0] {
		MCE_RTM_IDLE = 2'h0,
		MCE_RTM_SHIFT = 2'h1
	} mce_monitor_enable;
endpackage : mce_pkg

// file: core/mce_ram_if.sv
// Purpose: Port of the shared data memory
// Assumes: Single clock, registered read data
// Notes: Arbiter drives, memory answers one cycle later
`timescale 1ns/100ps
`default_nettype none
interface mce_ram_if;
	logic [9:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic we;
	modport ctl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface : mce_ram_if
`default_nettype wire

// file: core/mce_ram.sv
// Purpose: Shared data memory, 1024 words of 32 bits
// Assumes: One access per clock, chosen by the arbiter
// Notes: Read data come out of a register
`timescale 1ns/100ps
`default_nettype none
module mce_ram (
	input wire logic hclk,
	input wire logic hresetn,
	mce_ram_if.mem ram
);
	logic [31:0] mem_ff [1024];
	logic [31:0] rdata_ff;
	always_ff @(posedge hclk) begin
		if (ram.we) begin
			mem_ff[ram.addr] <= ram.wdata;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= mem_ff[ram.addr];
		end
	end
	assign ram.rdata = rdata_ff;
endmodule : mce_ram
`default_nettype wire

// file: core/mce_rtm.sv
// Purpose: Serialiser of the four monitor words
// Assumes: test_clock is slow and synchronous to hclk
// Notes: Shifts on sampled rising edges of test_clock
`timescale 1ns/100ps
`default_nettype none
`include "mce_params.svh"
module mce_rtm (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic monitor_enable,
	input wire logic test_clock,
	input wire logic start,
	input wire logic [127:0] words,
	output logic test_mux_output,
	output logic busy
);
	mce_pkg::mce_monitor_enable state_ff;
	logic tclk_q_ff;
	logic [5:0] bit_ff;
	logic [1:0] word_ff;
	logic [127:0] words_ff;
	logic out_ff;
	logic tick;
	logic [34:0] frame;
	assign tick = test_clock & ~tclk_q_ff;
	// Flag bit, then the word MSB first, then two idle zeros
	assign frame = {1'b1, words_ff[word_ff*32 +: 32], 2'b00};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tclk_q_ff <= 1'b0;
		end else begin
			tclk_q_ff <= test_clock;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= mce_pkg::MCE_RTM_IDLE;
			bit_ff <= 6'h0;
			word_ff <= 2'h0;
			words_ff <= 128'h0;
			out_ff <= 1'b0;
		end else if (!monitor_enable) begin
			state_ff <= mce_pkg::MCE_RTM_IDLE;
			out_ff <= 1'b0;
		end else begin
			case (state_ff)
				mce_pkg::MCE_RTM_IDLE: begin
					out_ff <= 1'b0;
					if (start) begin
						state_ff <= mce_pkg::MCE_RTM_SHIFT;
						words_ff <= words;
						bit_ff <= 6'h0;
						word_ff <= 2'h0;
					end
				end
				mce_pkg::MCE_RTM_SHIFT: begin
					if (tick) begin
						out_ff <= frame[6'd34 - bit_ff];
						if (bit_ff == `MCE_RTM_LAST_BIT) begin
							bit_ff <= 6'h0;
							word_ff <= word_ff + 2'h1;
							if (word_ff == `MCE_RTM_LAST_WORD) begin
								state_ff <= mce_pkg::MCE_RTM_IDLE;
							end
						end else begin
							bit_ff <= bit_ff + 6'h1;
						end
					end
				end
				default: state_ff <= mce_pkg::MCE_RTM_IDLE;
			endcase
		end
	end
	assign test_mux_output = out_ff;
	assign busy = (state_ff == mce_pkg::MCE_RTM_SHIFT);
	property p_rtm_low;
		@(posedge hclk) disable iff (!hresetn) !monitor_enable |=> !test_mux_output;
	endproperty
	a_rtm_low: assert property (p_rtm_low) else $error("monitor output not low");
	property p_rtm_bits;
		@(posedge hclk) disable iff (!hresetn) busy |-> bit_ff <= `MCE_RTM_LAST_BIT;
	endproperty
	a_rtm_bits: assert property (p_rtm_bits) else $error("monitor bit count beyond 35");
	c_rtm_word: cover property (@(posedge hclk) disable iff (!hresetn)
		busy && tick && bit_ff == `MCE_RTM_LAST_BIT);
endmodule : mce_rtm
`default_nettype wire

// file: core/mce_top.sv
// Purpose: Support hardware around the metering compute engine
// Assumes: AHB-Lite register bus, all inputs synchronous to hclk
// Notes: Shared memory rotates four slots: cpu, engine, cpu, spi or monitor
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mce_params.svh"
module mce_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic frame_sync,
	input wire logic alt_frame,
	input wire logic test_clock,
	input wire logic ce_halt,
	input wire logic ce_pulse_export,
	input wire logic ce_real_sign,
	input wire logic ce_reactive_sign,
	input wire logic ce_aux_x,
	input wire logic ce_aux_y,
	input wire logic ce_req,
	input wire logic ce_we,
	input wire logic [9:0] ce_addr,
	input wire logic [31:0] ce_wdata,
	output logic [31:0] ce_rdata,
	output logic ce_ack,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [11:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_ack,
	input wire logic spi_req,
	input wire logic spi_we,
	input wire logic [9:0] spi_addr,
	input wire logic [31:0] spi_wdata,
	output logic [31:0] spi_rdata,
	output logic spi_ack,
	output logic [2:0] equation_select,
	output logic ce_pass_start,
	output logic ce_alt_fill,
	output logic accumulation_done_irq,
	output logic cycle_end_irq,
	output logic real_energy_pulse,
	output logic reactive_energy_pulse,
	output logic aux_pulse_x,
	output logic aux_pulse_y,
	output logic test_mux_output
);
	function automatic logic [9:0] interval_cycles(input logic [7:0] intv);
		interval_cycles = {intv, 2'b00} - 10'h1;
	endfunction : interval_cycles

	mce_ram_if ram ();
	logic ap_valid_ff, ap_write_ff, ap;
	logic [13:0] ap_idx_ff;
	logic [31:0] hrdata_ff;
	logic [2:0] equ_ff;
	logic mon_en_ff, inv_ff;
	logic [7:0] acc_cfg_ff, intv_ff, wlim_ff;
	logic [9:0] mon_addr_ff [4];
	logic [31:0] rd_mux;
	logic [13:0] rd_idx;
	mce_pkg::mce_pass_e pass_ff;
	logic fs_q_ff, frame_rise;
	logic pass_start_ff, alt_ff, acc_irq_ff, cyc_irq_ff;
	logic [8:0] frame_cnt_ff, acc_target;
	logic [1:0] slot_ff;
	logic cpu_rd_ff, cpu_wr_ff, ce_go_ff, spi_go_ff, fet_go_ff;
	logic [9:0] cpu_word_ff;
	logic [1:0] cpu_lane_ff;
	logic [7:0] cpu_byte_ff, cpu_rdata_ff;
	logic [31:0] merged_ff, ce_rdata_ff, spi_rdata_ff;
	logic cpu_ack_ff, ce_ack_ff, spi_ack_ff;
	logic [1:0] fet_idx_ff;
	logic [127:0] mon_words_ff;
	logic rtm_start_ff, rtm_busy;
	logic [1:0] fifo_ff [4];
	logic [1:0] wr_ptr_ff, rd_ptr_ff;
	logic [2:0] fifo_cnt_ff;
	logic [9:0] timer_ff;
	logic expire, bypass, upd;
	logic [1:0] upd_sign;
	logic [1:0] act_ff;
	logic [8:0] wcnt_ff [2];
	logic [1:0] aux_ff;
	logic [3:0] pin_ff;

	// Zero wait state slave; every answer is OKAY
	assign ap = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign rd_idx = (haddr[31:16] == 16'h0) ? haddr[15:2] : `MCE_IDX_NONE;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_ff <= 1'b0;
			ap_write_ff <= 1'b0;
			ap_idx_ff <= `MCE_IDX_NONE;
		end else begin
			ap_valid_ff <= ap;
			ap_write_ff <= hwrite;
			ap_idx_ff <= rd_idx;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			equ_ff <= `MCE_EQU_RST;
			mon_en_ff <= 1'b0;
			inv_ff <= 1'b0;
			acc_cfg_ff <= `MCE_ACC_RST;
			intv_ff <= `MCE_INTV_RST;
			wlim_ff <= `MCE_WLIM_RST;
			for (int i = 0; i < 4; i++) begin
				mon_addr_ff[i] <= 10'h0;
			end
		end else if (ap_valid_ff && ap_write_ff) begin
			case (ap_idx_ff)
				`MCE_IDX_CTRL: begin
					// Codes above the last wiring code are ignored
					if (hwdata[`MCE_CTRL_EQU_MSB:`MCE_CTRL_EQU_LSB] <= `MCE_EQU_MAX) begin
						equ_ff <= hwdata[`MCE_CTRL_EQU_MSB:`MCE_CTRL_EQU_LSB];
					end
					mon_en_ff <= hwdata[`MCE_CTRL_MON_EN];
					inv_ff <= hwdata[`MCE_CTRL_INV];
				end
				`MCE_IDX_ACC: acc_cfg_ff <= hwdata[7:0];
				`MCE_IDX_INTV: intv_ff <= hwdata[7:0];
				`MCE_IDX_WLIM: wlim_ff <= hwdata[7:0];
				default: begin
					if (ap_idx_ff >= `MCE_IDX_MON0 && ap_idx_ff <= `MCE_IDX_MON3) begin
						mon_addr_ff[ap_idx_ff[1:0]] <= hwdata[9:0];
					end
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		case (rd_idx)
			`MCE_IDX_CTRL: rd_mux = {27'h0, inv_ff, mon_en_ff, equ_ff};
			`MCE_IDX_ACC: rd_mux = {24'h0, acc_cfg_ff};
			`MCE_IDX_INTV: rd_mux = {24'h0, intv_ff};
			`MCE_IDX_WLIM: rd_mux = {24'h0, wlim_ff};
			`MCE_IDX_STAT: rd_mux = {16'h0, pass_ff, rtm_busy, fifo_cnt_ff, 1'b0, frame_cnt_ff};
			default: begin
				if (rd_idx >= `MCE_IDX_MON0 && rd_idx <= `MCE_IDX_MON3) begin
					rd_mux = {22'h0, mon_addr_ff[rd_idx[1:0]]};
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0;
		end else if (ap && !hwrite) begin
			hrdata_ff <= rd_mux;
		end
	end

	// Frame start drives the pass, the interrupts and accumulation
	assign frame_rise = frame_sync & ~fs_q_ff;
	assign acc_target = {7'h0, acc_cfg_ff[`MCE_PRE_MSB:`MCE_PRE_LSB]} + 9'h1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_q_ff <= 1'b0;
			pass_start_ff <= 1'b0;
			cyc_irq_ff <= 1'b0;
			acc_irq_ff <= 1'b0;
			alt_ff <= 1'b0;
			frame_cnt_ff <= 9'h0;
		end else begin
			fs_q_ff <= frame_sync;
			pass_start_ff <= frame_rise;
			cyc_irq_ff <= frame_rise;
			acc_irq_ff <= 1'b0;
			if (frame_rise) begin
				alt_ff <= alt_frame;
				// Frames per accumulation: (presample+1) * (summation+1)
				if (frame_cnt_ff + 9'h1 >= 9'(acc_target *
					({3'h0, acc_cfg_ff[`MCE_SUM_MSB:`MCE_SUM_LSB]} + 9'h1))) begin
					frame_cnt_ff <= 9'h0;
					acc_irq_ff <= 1'b1;
				end else begin
					frame_cnt_ff <= frame_cnt_ff + 9'h1;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pass_ff <= mce_pkg::MCE_PASS_IDLE;
		end else begin
			case (pass_ff)
				mce_pkg::MCE_PASS_IDLE: begin
					if (frame_rise) pass_ff <= mce_pkg::MCE_PASS_FETCH;
				end
				mce_pkg::MCE_PASS_FETCH: begin
					if (fet_go_ff && fet_idx_ff == 2'h3) pass_ff <= mce_pkg::MCE_PASS_RUN;
				end
				mce_pkg::MCE_PASS_RUN: begin
					if (frame_rise) begin
						pass_ff <= mce_pkg::MCE_PASS_FETCH;
					end else if (ce_halt) begin
						pass_ff <= mce_pkg::MCE_PASS_IDLE;
					end
				end
				default: pass_ff <= mce_pkg::MCE_PASS_IDLE;
			endcase
		end
	end

	// Slot rotation; a cpu byte write uses slot 0 to read and slot 2 to write
	always_comb begin
		ram.addr = 10'h0;
		ram.wdata = 32'h0;
		ram.we = 1'b0;
		case (slot_ff)
			2'h0: ram.addr = cpu_addr[11:2];
			2'h1: begin
				ram.addr = ce_addr;
				ram.wdata = ce_wdata;
				ram.we = ce_req & ce_we;
			end
			2'h2: begin
				ram.addr = cpu_word_ff;
				ram.wdata = merged_ff;
				ram.we = cpu_wr_ff;
			end
			default: begin
				if (pass_ff == mce_pkg::MCE_PASS_FETCH) begin
					ram.addr = mon_addr_ff[fet_idx_ff];
				end else begin
					ram.addr = spi_addr;
					ram.wdata = spi_wdata;
					ram.we = spi_req & spi_we;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot_ff <= 2'h0;
			cpu_rd_ff <= 1'b0;
			cpu_wr_ff <= 1'b0;
			ce_go_ff <= 1'b0;
			spi_go_ff <= 1'b0;
			fet_go_ff <= 1'b0;
			cpu_word_ff <= 10'h0;
			cpu_lane_ff <= 2'h0;
			cpu_byte_ff <= 8'h0;
			cpu_rdata_ff <= 8'h0;
			merged_ff <= 32'h0;
			ce_rdata_ff <= 32'h0;
			spi_rdata_ff <= 32'h0;
			cpu_ack_ff <= 1'b0;
			ce_ack_ff <= 1'b0;
			spi_ack_ff <= 1'b0;
		end else begin
			slot_ff <= slot_ff + 2'h1;
			cpu_ack_ff <= 1'b0;
			ce_ack_ff <= 1'b0;
			spi_ack_ff <= 1'b0;
			ce_go_ff <= (slot_ff == 2'h1) && ce_req;
			spi_go_ff <= (slot_ff == 2'h3) && spi_req && (pass_ff != mce_pkg::MCE_PASS_FETCH);
			fet_go_ff <= (slot_ff == 2'h3) && (pass_ff == mce_pkg::MCE_PASS_FETCH);
			if (slot_ff == 2'h0) begin
				cpu_rd_ff <= cpu_req;
				cpu_wr_ff <= 1'b0;
				cpu_word_ff <= cpu_addr[11:2];
				cpu_lane_ff <= cpu_addr[1:0];
				cpu_byte_ff <= cpu_wdata;
			end
			if (slot_ff == 2'h1 && cpu_rd_ff) begin
				cpu_rd_ff <= 1'b0;
				cpu_rdata_ff <= ram.rdata[cpu_lane_ff*8 +: 8];
				merged_ff <= ram.rdata;
				merged_ff[cpu_lane_ff*8 +: 8] <= cpu_byte_ff;
				cpu_wr_ff <= cpu_we;
				cpu_ack_ff <= ~cpu_we;
			end
			if (slot_ff == 2'h2 && cpu_wr_ff) begin
				cpu_wr_ff <= 1'b0;
				cpu_ack_ff <= 1'b1;
			end
			if (ce_go_ff) begin
				ce_rdata_ff <= ram.rdata;
				ce_ack_ff <= 1'b1;
			end
			if (spi_go_ff) begin
				spi_rdata_ff <= ram.rdata;
				spi_ack_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fet_idx_ff <= 2'h0;
			mon_words_ff <= 128'h0;
			rtm_start_ff <= 1'b0;
		end else begin
			rtm_start_ff <= 1'b0;
			if (frame_rise) begin
				fet_idx_ff <= 2'h0;
			end else if (fet_go_ff) begin
				mon_words_ff[fet_idx_ff*32 +: 32] <= ram.rdata;
				fet_idx_ff <= fet_idx_ff + 2'h1;
				rtm_start_ff <= (fet_idx_ff == 2'h3);
			end
		end
	end

	mce_ram mce_ram_inst (
		.hclk(hclk),
		.hresetn(hresetn),
		.ram(ram)
	);

	mce_rtm mce_rtm_inst (
		.hclk(hclk),
		.hresetn(hresetn),
		.monitor_enable(mon_en_ff),
		.test_clock(test_clock),
		.start(rtm_start_ff),
		.words(mon_words_ff),
		.test_mux_output(test_mux_output),
		.busy(rtm_busy)
	);

	// Sign queue; overflow beyond four entries is dropped
	assign bypass = (intv_ff == 8'h0);
	assign expire = (timer_ff == 10'h0);
	assign upd = bypass ? ce_pulse_export : (expire && fifo_cnt_ff != 3'h0 && !frame_rise);
	assign upd_sign = bypass ? {ce_reactive_sign, ce_real_sign} : fifo_ff[rd_ptr_ff];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_ff <= 2'h0;
			rd_ptr_ff <= 2'h0;
			fifo_cnt_ff <= 3'h0;
			timer_ff <= 10'h0;
			for (int i = 0; i < 4; i++) begin
				fifo_ff[i] <= 2'h0;
			end
		end else if (frame_rise || bypass) begin
			wr_ptr_ff <= 2'h0;
			rd_ptr_ff <= 2'h0;
			fifo_cnt_ff <= 3'h0;
			timer_ff <= interval_cycles(intv_ff);
		end else begin
			timer_ff <= expire ? interval_cycles(intv_ff) : timer_ff - 10'h1;
			if (ce_pulse_export && fifo_cnt_ff != `MCE_FIFO_DEPTH) begin
				fifo_ff[wr_ptr_ff] <= {ce_reactive_sign, ce_real_sign};
				wr_ptr_ff <= wr_ptr_ff + 2'h1;
			end
			if (upd) begin
				rd_ptr_ff <= rd_ptr_ff + 2'h1;
			end
			fifo_cnt_ff <= fifo_cnt_ff
				+ {2'h0, ce_pulse_export && fifo_cnt_ff != `MCE_FIFO_DEPTH}
				- {2'h0, upd};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_ff <= 2'h0;
			wcnt_ff[0] <= 9'h0;
			wcnt_ff[1] <= 9'h0;
		end else if (upd) begin
			for (int i = 0; i < 2; i++) begin
				if (!upd_sign[i]) begin
					act_ff[i] <= 1'b0;
					wcnt_ff[i] <= 9'h0;
				end else if (wlim_ff != `MCE_WLIM_OFF && wcnt_ff[i] >= {wlim_ff, 1'b1}) begin
					act_ff[i] <= 1'b0;
				end else begin
					act_ff[i] <= 1'b1;
					wcnt_ff[i] <= wcnt_ff[i] + 9'h1;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aux_ff <= 2'h0;
		end else if (ce_halt && pass_ff == mce_pkg::MCE_PASS_RUN) begin
			aux_ff <= {ce_aux_y, ce_aux_x};
		end
	end

	// Idle pins are high unless inverted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_ff <= 4'hf;
		end else begin
			pin_ff <= {aux_ff, act_ff} ^ {4{~inv_ff}};
		end
	end

	assign real_energy_pulse = pin_ff[0];
	assign reactive_energy_pulse = pin_ff[1];
	assign aux_pulse_x = pin_ff[2];
	assign aux_pulse_y = pin_ff[3];
	assign equation_select = equ_ff;
	assign ce_pass_start = pass_start_ff;
	assign ce_alt_fill = alt_ff;
	assign accumulation_done_irq = acc_irq_ff;
	assign cycle_end_irq = cyc_irq_ff;
	assign cpu_rdata = cpu_rdata_ff;
	assign cpu_ack = cpu_ack_ff;
	assign ce_rdata = ce_rdata_ff;
	assign ce_ack = ce_ack_ff;
	assign spi_rdata = spi_rdata_ff;
	assign spi_ack = spi_ack_ff;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_equ_range;
		equation_select <= `MCE_EQU_MAX;
	endproperty
	a_equ_range: assert property (p_equ_range) else $error("equation code out of range");
	property p_pass_start;
		frame_rise |=> ce_pass_start && cycle_end_irq;
	endproperty
	a_pass_start: assert property (p_pass_start) else $error("no pass start at frame");
	property p_fifo_clear;
		frame_rise |=> fifo_cnt_ff == 3'h0;
	endproperty
	a_fifo_clear: assert property (p_fifo_clear) else $error("queue kept at frame");
	// Active when the real sign is set, unless the width limit had already been reached
	property p_bypass;
		bypass && ce_pulse_export |=> act_ff[0] == ($past(ce_real_sign) &&
			($past(wlim_ff) == `MCE_WLIM_OFF || $past(wcnt_ff[0]) < {$past(wlim_ff), 1'b1}));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not update");
	property p_polarity;
		!inv_ff ##1 !inv_ff && act_ff[0] == $past(act_ff[0]) |-> real_energy_pulse == !act_ff[0];
	endproperty
	a_polarity: assert property (p_polarity) else $error("pulse polarity wrong");
	property p_width;
		wlim_ff != `MCE_WLIM_OFF && $stable(wlim_ff) |-> wcnt_ff[0] <= {wlim_ff, 1'b1};
	endproperty
	a_width: assert property (p_width) else $error("pulse width beyond limit");
	property p_acc_done;
		accumulation_done_irq |-> frame_cnt_ff == 9'h0 && $past(frame_rise);
	endproperty
	a_acc_done: assert property (p_acc_done) else $error("stray accumulation interrupt");
	property p_rmw;
		slot_ff == 2'h0 && cpu_req && cpu_we ##1 cpu_rd_ff |=> ram.we ##1 cpu_ack;
	endproperty
	a_rmw: assert property (p_rmw) else $error("byte write not read-modify-write");
	property p_pop_timing;
		!bypass && upd |-> timer_ff == 10'h0;
	endproperty
	a_pop_timing: assert property (p_pop_timing) else $error("queue popped off interval");
	c_queue_pop: cover property (!bypass && upd ##[1:40] upd);
	c_acc_done: cover property (accumulation_done_irq);
	c_byte_write: cover property (cpu_ack && cpu_wr_ff == 1'b0 && $past(ram.we));
endmodule : mce_top
`default_nettype wire

// file: dv/mce_ce_model.sv
// Purpose: Engine firmware model, exports sign bits and halts passes
// Assumes: Commands come from the bench one cycle ahead
// Notes: Idle data lines toggle so a stale value never looks valid
`timescale 1ns/100ps
`default_nettype none
module mce_ce_model (
	input wire logic hclk,
	input wire logic fire,
	input wire logic stop,
	input wire logic [1:0] v,
	output logic exp_o,
	output logic rsign,
	output logic qsign,
	output logic halt,
	output logic ax,
	output logic ay
);
	initial {exp_o, rsign, qsign, halt, ax, ay} = 6'h00;
	always @(posedge hclk) begin
		exp_o <= fire;
		rsign <= fire ? v[0] : ~rsign;
		qsign <= fire ? v[1] : ~qsign;
		halt <= stop;
		ax <= stop ? v[0] : ~ax;
		ay <= stop ? v[1] : ~ay;
	end
endmodule : mce_ce_model
`default_nettype wire

// file: dv/mce_top_tb.sv
// Purpose: Self-checking bench of the engine support block
// Assumes: Registers at byte address four times the index
// Notes: Engine side is the model; memory ports are driven by tasks
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mce_top_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, frame_sync = 0, alt_frame = 0;
	logic test_clock = 0, fire = 0, stop = 0, ce_req = 0, ce_we = 0;
	logic cpu_req = 0, cpu_we = 0, spi_req = 0, spi_we = 0;
	logic [1:0] htrans = 0, v = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, rd, ce_wdata = 0, spi_wdata = 0;
	logic [9:0] ce_addr = 0, spi_addr = 0;
	logic [11:0] cpu_addr = 0;
	logic [7:0] cpu_wdata = 0, cpu_rdata;
	logic [31:0] hrdata, ce_rdata, spi_rdata;
	logic [2:0] equation_select;
	logic hreadyout, hresp, ce_ack, cpu_ack, spi_ack, ce_pass_start, ce_alt_fill;
	logic accumulation_done_irq, cycle_end_irq, real_energy_pulse, reactive_energy_pulse;
	logic aux_pulse_x, aux_pulse_y, test_mux_output;
	logic ce_pulse_export, ce_real_sign, ce_reactive_sign, ce_halt, ce_aux_x, ce_aux_y;
	int mismatches = 0, check_count = 0, cyc = 0, n_acc = 0, n_cyc = 0, a0, c0;
	mce_top mce_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frame_sync, .alt_frame,
		.test_clock, .ce_halt, .ce_pulse_export, .ce_real_sign, .ce_reactive_sign,
		.ce_aux_x, .ce_aux_y, .ce_req, .ce_we, .ce_addr, .ce_wdata, .ce_rdata, .ce_ack,
		.cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .spi_req, .spi_we,
		.spi_addr, .spi_wdata, .spi_rdata, .spi_ack, .equation_select, .ce_pass_start,
		.ce_alt_fill, .accumulation_done_irq, .cycle_end_irq, .real_energy_pulse,
		.reactive_energy_pulse, .aux_pulse_x, .aux_pulse_y, .test_mux_output);
	mce_ce_model mce_ce_model_inst (.hclk, .fire, .stop, .v, .exp_o(ce_pulse_export),
		.rsign(ce_real_sign), .qsign(ce_reactive_sign), .halt(ce_halt), .ax(ce_aux_x),
		.ay(ce_aux_y));
	always #10 hclk = ~hclk;
	always #100 test_clock = ~test_clock;
	// Ceiling well above the six to seven hundred cycles the tests take
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		n_acc <= n_acc + int'(accumulation_done_irq === 1'b1);
		n_cyc <= n_cyc + int'(cycle_end_irq === 1'b1);
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic w(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : w
	task automatic frame();
		@(posedge hclk);
		frame_sync <= 1;
		repeat (2) @(posedge hclk);
		frame_sync <= 0;
	endtask : frame
	task automatic ex(input logic [1:0] s, input logic h);
		@(posedge hclk);
		fire <= !h;
		stop <= h;
		v <= s;
		@(posedge hclk);
		fire <= 0;
		stop <= 0;
	endtask : ex
	task automatic t_reset();
		`CHK({real_energy_pulse, reactive_energy_pulse, aux_pulse_x, aux_pulse_y}, 4'hf)
		bus(0, 32'h8000, 0);
		`CHK(rd, 32'h0)
		bus(0, 32'h8004, 0);
		`CHK(rd, 32'h0)
		bus(0, 32'h800c, 0);
		`CHK(rd, 32'hff)
		bus(0, 32'h8040, 0);
		`CHK(rd, 32'h0)
		$display("test reset done");
	endtask : t_reset
	task automatic t_equ();
		for (int i = 0; i < 8; i++) begin
			bus(1, 32'h8000, i);
			w(1);
			`CHK(equation_select, i <= 5 ? 3'(i) : 3'h5)
		end
		bus(1, 32'h8000, 32'h10);
		w(1);
		`CHK({real_energy_pulse, reactive_energy_pulse, aux_pulse_x, aux_pulse_y}, 4'h0)
		bus(1, 32'h8000, 0);
		$display("test equation and polarity done");
	endtask : t_equ
	task automatic t_bypass();
		ex(2'h1, 0);
		w(3);
		`CHK({real_energy_pulse, reactive_energy_pulse}, 2'h1)
		ex(2'h0, 0);
		bus(1, 32'h800c, 0);
		ex(2'h1, 0);
		w(3);
		`CHK(real_energy_pulse, 1'b0)
		ex(2'h1, 0);
		w(3);
		`CHK(real_energy_pulse, 1'b1)
		bus(1, 32'h800c, 32'hff);
		ex(2'h0, 0);
		ex(2'h1, 0);
		ex(2'h1, 0);
		w(3);
		`CHK(real_energy_pulse, 1'b0)
		ex(2'h0, 0);
		$display("test bypass and width done");
	endtask : t_bypass
	task automatic t_queue();
		bus(1, 32'h8008, 3);
		frame();
		ex(2'h1, 0);
		w(1);
		`CHK(real_energy_pulse, 1'b1)
		ex(2'h2, 0);
		w(12);
		`CHK({real_energy_pulse, reactive_energy_pulse}, 2'h1)
		w(12);
		`CHK({real_energy_pulse, reactive_energy_pulse}, 2'h2)
		ex(2'h3, 0);
		frame();
		w(16);
		`CHK({real_energy_pulse, reactive_energy_pulse}, 2'h2)
		bus(1, 32'h8008, 0);
		$display("test queue done");
	endtask : t_queue
	task automatic t_pass();
		bus(1, 32'h8004, 32'h40);
		a0 = n_acc;
		c0 = n_cyc;
		alt_frame <= 1;
		frame();
		w(2);
		`CHK(n_acc, a0)
		frame();
		w(24);
		`CHK(ce_alt_fill, 1'b1)
		alt_frame <= 0;
		ex(2'h1, 1);
		w(4);
		`CHK({aux_pulse_x, aux_pulse_y}, 2'h1)
		`CHK(n_acc, a0 + 1)
		`CHK(n_cyc, c0 + 2)
		`CHK(test_mux_output, 1'b0)
		$display("test pass and interrupts done");
	endtask : t_pass
	task automatic ce_acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge hclk);
		ce_req <= 1;
		ce_we <= wr;
		ce_addr <= a;
		ce_wdata <= d;
		do @(posedge hclk); while (ce_ack !== 1'b1);
		rd = ce_rdata;
		ce_req <= 0;
	endtask : ce_acc
	// One access at a time, each waits for its ack
	task automatic cpu_acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge hclk);
		cpu_req <= 1;
		cpu_we <= wr;
		cpu_addr <= a;
		cpu_wdata <= d;
		do @(posedge hclk); while (cpu_ack !== 1'b1);
		rd = {24'h0, cpu_rdata};
		cpu_req <= 0;
	endtask : cpu_acc
	task automatic spi_acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge hclk);
		spi_req <= 1;
		spi_we <= wr;
		spi_addr <= a;
		spi_wdata <= d;
		do @(posedge hclk); while (spi_ack !== 1'b1);
		rd = spi_rdata;
		spi_req <= 0;
	endtask : spi_acc
	task automatic t_ram();
		ce_acc(1, 10'h5, 32'h12345678);
		cpu_acc(1, 12'h16, 8'hab);
		cpu_acc(0, 12'h16, 8'h0);
		`CHK(rd, 32'hab)
		ce_acc(0, 10'h5, 32'h0);
		`CHK(rd, 32'h12ab5678)
		spi_acc(1, 10'h6, 32'h0badcafe);
		spi_acc(0, 10'h5, 32'h0);
		`CHK(rd, 32'h12ab5678)
		ce_acc(0, 10'h6, 32'h0);
		`CHK(rd, 32'h0badcafe)
		$display("test shared ram done");
	endtask : t_ram
	task automatic t_mon();
		logic [33:0] got;
		bus(1, 32'h8010, 32'h5);
		bus(1, 32'h8000, 32'h8);
		frame();
		while (test_mux_output !== 1'b1) @(posedge hclk);
		// Sample mid-bit, on the falling test clock
		@(negedge test_clock);
		for (int i = 0; i < 34; i++) begin
			@(negedge test_clock);
			got = {got[32:0], test_mux_output};
		end
		`CHK(got, {32'h12ab5678, 2'b00})
		bus(1, 32'h8000, 0);
		w(2);
		`CHK(test_mux_output, 1'b0)
		$display("test monitor done");
	endtask : t_mon
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		t_reset();
		t_equ();
		t_bypass();
		t_queue();
		t_pass();
		t_ram();
		t_mon();
		end_sim();
	end
endmodule : mce_top_tb
`default_nettype wire
